// File: hw/pit_regs.vh
// Constants for the three-counter interval timer bus and programming block
`ifndef PIT_REGS_VH
`define PIT_REGS_VH

// ----------------------------------------------------------------
// Port selection
// ----------------------------------------------------------------
`define PIT_SEL_SETUP      2'h3
`define PIT_NUM_CNT        3

// ----------------------------------------------------------------
// Setup word field positions
// ----------------------------------------------------------------
`define PIT_SW_SEL_HI      7
`define PIT_SW_SEL_LO      6
`define PIT_SW_FMT_HI      5
`define PIT_SW_FMT_LO      4
`define PIT_SW_MODE_HI     3
`define PIT_SW_MODE_LO     1
`define PIT_SW_BCD         0
`define PIT_SEL_READBACK   2'h3

// ----------------------------------------------------------------
// Access format codes
// ----------------------------------------------------------------
`define PIT_FMT_LATCH      2'h0
`define PIT_FMT_LOW        2'h1
`define PIT_FMT_HIGH       2'h2
`define PIT_FMT_BOTH       2'h3

// ----------------------------------------------------------------
// Readback command bits (active low latch requests)
// ----------------------------------------------------------------
`define PIT_RB_NCOUNT      5
`define PIT_RB_NSTATUS     4
`define PIT_RB_CNT0        1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIT_SETUP_RST      6'h00
`define PIT_COUNT_RST      16'h0000

`endif

// File: hw/pit_edge.v
// Rising edge detector for a counter clock pin sampled on the system clock
`timescale 1ns/100ps
module pit_edge (
  input  wire clk,
  input  wire rst,
  input  wire level,
  output reg  rise
);

  reg level_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
      rise    <= 1'b0;
    end else begin
      level_q <= level;
      rise    <= level & ~level_q;
    end
  end

endmodule // pit_edge

// File: hw/pit_dec.v
// Binary or four-decade decimal decrement of a 16-bit count value
`timescale 1ns/100ps
module pit_dec (
  input  wire [15:0] value,
  input  wire        bcd,
  output wire [15:0] next_value
);

  wire [4:0]  borrow;
  wire [15:0] bcd_val;

  assign borrow[0] = 1'b1;

  // Each decade borrows from the next only when it wraps 0 to 9
  genvar d;
  generate
    for (d = 0; d < 4; d = d + 1) begin : g_digit
      wire [3:0] dig = value[4*d+3:4*d];
      assign bcd_val[4*d+3:4*d] = !borrow[d]     ? dig :
                                  (dig == 4'h0)  ? 4'h9 : dig - 4'h1;
      assign borrow[d+1] = borrow[d] & (dig == 4'h0);
    end
  endgenerate

  assign next_value = bcd ? bcd_val : value - 16'h0001;

endmodule // pit_dec

// File: hw/pit_top.v
// Interval timer: bus decode, setup words, preset, counting and snapshot logic
`timescale 1ns/100ps
`include "pit_regs.vh"
module pit_top #(
  parameter NUM_CNT = `PIT_NUM_CNT
) (
  input  wire                clk,
  input  wire                rst,
  input  wire [7:0]          data_in,
  output reg  [7:0]          data_out,
  output reg                 data_oe,
  input  wire [1:0]          port_select_bits,
  input  wire                cs_n,
  input  wire                rd_n,
  input  wire                wr_n,
  input  wire [NUM_CNT-1:0]  count_clk,
  input  wire [NUM_CNT-1:0]  count_enable,
  output reg  [NUM_CNT-1:0]  count_out
);

  // ----------------------------------------------------------------
  // Strobe tracking
  // ----------------------------------------------------------------
  reg                wr_n_q;
  reg                rd_n_q;
  wire               wr_evt;
  wire               rd_evt;
  wire               setup_wr;
  wire               readback;
  wire [1:0]         sw_sel;
  wire [1:0]         sw_fmt;
  wire [7:0]         cnt_rdata [0:NUM_CNT-1];
  wire [NUM_CNT-1:0] cnt_out_w;
  wire               rd_sel;
  wire [2:0]         sw_mode;
  wire               sw_bcd;
  reg  [7:0]         rd_byte;
  integer            k;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else begin
      wr_n_q <= wr_n;
      rd_n_q <= rd_n;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Writes take effect on the rising write strobe, while still selected
  assign wr_evt   = !wr_n_q && wr_n && !cs_n;
  // A read completes when the read strobe rises; this steps byte order
  assign rd_evt   = !rd_n_q && rd_n && !cs_n;
  assign setup_wr = wr_evt && (port_select_bits == `PIT_SEL_SETUP);
  assign sw_sel   = data_in[`PIT_SW_SEL_HI:`PIT_SW_SEL_LO];
  assign sw_fmt   = data_in[`PIT_SW_FMT_HI:`PIT_SW_FMT_LO];
  assign readback = setup_wr && (sw_sel == `PIT_SEL_READBACK);
  // Setup register never answers a read
  assign rd_sel   = !cs_n && !rd_n && (port_select_bits != `PIT_SEL_SETUP);
  assign sw_mode  = data_in[`PIT_SW_MODE_HI:`PIT_SW_MODE_LO];
  assign sw_bcd   = data_in[`PIT_SW_BCD];

  // ----------------------------------------------------------------
  // Read byte select
  // ----------------------------------------------------------------
  // Select 11 matches no counter, so nothing indexes past the array
  always @* begin
    rd_byte = 8'h00;
    for (k = 0; k < NUM_CNT; k = k + 1) begin
      if (port_select_bits == k[1:0]) begin
        rd_byte = cnt_rdata[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Data buffer
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= rd_sel;
      if (rd_sel) begin
        data_out <= rd_byte;
      end else begin
        // Idle value is fixed so a released bus shows nothing stale
        data_out <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter outputs
  // ----------------------------------------------------------------
  // One more register stage so every pin leaves straight from a flop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_out <= {NUM_CNT{1'b0}};
    end else begin
      count_out <= cnt_out_w;
    end
  end

  // ----------------------------------------------------------------
  // Counters, one copy each, sharing nothing but the bus
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_CNT; i = i + 1) begin : g_cnt
      wire        addr_hit;
      wire        cnt_wr;
      wire        cnt_rd;
      wire        setup_hit;
      wire        latch_cmd;
      wire        status_cmd;
      wire        tick;
      wire [15:0] ce_dec;
      reg  [2:0]  mode;
      reg  [1:0]  fmt;
      reg         bcd;
      reg  [15:0] ce;
      reg  [7:0]  preset_low_byte;
      reg  [7:0]  preset_high_byte;
      reg         wr_second;
      reg         rd_second;
      reg         load_pend;
      reg         armed;
      reg         null_count;
      reg         out;
      reg         latched;
      reg  [15:0] count_snapshot_latch;
      reg         stat_latched;
      reg  [7:0]  status;
      reg  [7:0]  next_rdata;
      wire        step;
      wire        sel_hit;
      wire        rb_pick;
      wire [15:0] preset_word;
      wire        at_one;
      wire        at_two;
      // Compare against a sized copy of the loop index
      localparam [1:0] CNT_IDX = i;

      assign addr_hit    = (port_select_bits == CNT_IDX);
      assign cnt_wr      = wr_evt && addr_hit;
      assign cnt_rd      = rd_evt && addr_hit;
      assign sel_hit     = setup_wr && (sw_sel == CNT_IDX);
      assign setup_hit   = sel_hit && (sw_fmt != `PIT_FMT_LATCH);
      // Readback names its counters by one bit each, from bit 1 up
      assign rb_pick     = readback && data_in[`PIT_RB_CNT0+i];
      assign latch_cmd   = (sel_hit && (sw_fmt == `PIT_FMT_LATCH))
                         || (rb_pick && !data_in[`PIT_RB_NCOUNT]);
      assign status_cmd  = rb_pick && !data_in[`PIT_RB_NSTATUS];
      // A tick with the gate low must leave the pending load in place
      assign step        = tick && count_enable[i];
      assign preset_word = {preset_high_byte, preset_low_byte};
      assign at_one      = (ce == 16'h0001);
      assign at_two      = (ce == 16'h0002);
      assign cnt_out_w[i] = out;

      // The edge is seen one system clock after the pin rises
      pit_edge u_edge (
        .clk   (clk),
        .rst   (rst),
        .level (count_clk[i]),
        .rise  (tick)
      );

      // Decrement is formed every cycle; only a gated tick uses it
      pit_dec u_dec (
        .value      (ce),
        .bcd        (bcd),
        .next_value (ce_dec)
      );

      // ------------------------------------------------------------
      // Setup word and preset buffer
      // ------------------------------------------------------------
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          // Reset is a convenience; software must still program first
          mode             <= 3'h0;
          fmt              <= `PIT_FMT_LOW;
          bcd              <= 1'b0;
          preset_low_byte  <= 8'h00;
          preset_high_byte <= 8'h00;
          wr_second        <= 1'b0;
          load_pend        <= 1'b0;
        end else if (setup_hit) begin
          mode             <= sw_mode;
          fmt              <= sw_fmt;
          bcd              <= sw_bcd;
          preset_low_byte  <= 8'h00;
          preset_high_byte <= 8'h00;
          wr_second        <= 1'b0;
          load_pend        <= 1'b0;
        end else begin
          if (cnt_wr) begin
            case (fmt)
              `PIT_FMT_LOW: begin
                preset_low_byte <= data_in;
                load_pend       <= 1'b1;
              end
              `PIT_FMT_HIGH: begin
                preset_high_byte <= data_in;
                load_pend        <= 1'b1;
              end
              `PIT_FMT_BOTH: begin
                // Low byte first; only the high byte completes a count
                if (wr_second) begin
                  preset_high_byte <= data_in;
                  load_pend        <= 1'b1;
                end else begin
                  preset_low_byte <= data_in;
                end
                wr_second <= ~wr_second;
              end
              default: begin
                preset_low_byte <= preset_low_byte;
              end
            endcase
          end else if (load_pend && step) begin
            // Cleared by the same gated tick that moves the count
            load_pend <= 1'b0;
          end
        end
      end

      // ------------------------------------------------------------
      // Counting element and output
      // ------------------------------------------------------------
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          ce         <= `PIT_COUNT_RST;
          armed      <= 1'b0;
          null_count <= 1'b0;
          out        <= 1'b0;
        end else if (setup_hit) begin
          // Counting halts until a fresh count has been transferred
          armed      <= 1'b0;
          null_count <= 1'b1;
          out        <= (sw_mode != 3'h0);
        end else begin
          if (cnt_wr && (fmt != `PIT_FMT_LATCH)) begin
            null_count <= 1'b1;
          end
          // A count byte arriving with the tick defers the transfer
          if (step) begin
            if (load_pend && !cnt_wr) begin
              // Both bytes enter the element in one step
              ce         <= preset_word;
              armed      <= 1'b1;
              null_count <= 1'b0;
              if (mode == 3'h0) begin
                out <= 1'b0;
              end
            end else if (armed) begin
              if (mode[1] && at_one) begin
                // Periodic modes reload at the end of each period
                ce  <= preset_word;
                out <= mode[0] ? ~out : 1'b1;
              end else begin
                ce <= ce_dec;
                if (mode[1] && !mode[0] && at_two) begin
                  out <= 1'b0;
                end else if (!mode[1] && at_one) begin
                  out <= 1'b1;
                end
              end
            end
          end
        end
      end

      // ------------------------------------------------------------
      // Snapshot latch
      // ------------------------------------------------------------
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          count_snapshot_latch <= `PIT_COUNT_RST;
          latched              <= 1'b0;
        end else begin
          if (setup_hit) begin
            // Reprogramming releases any held count
            latched <= 1'b0;
          end else if (latch_cmd && !latched) begin
            latched <= 1'b1;
          end else if (cnt_rd && !stat_latched) begin
            if ((fmt != `PIT_FMT_BOTH) || rd_second) begin
              latched <= 1'b0;
            end
          end
          // A second latch before the read is ignored by holding here
          if (!latched) begin
            count_snapshot_latch <= ce;
          end
        end
      end

      // Byte pointer for two-byte reads; a status read does not step it
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          rd_second <= 1'b0;
        end else if (setup_hit) begin
          rd_second <= 1'b0;
        end else if (cnt_rd && !stat_latched && (fmt == `PIT_FMT_BOTH)) begin
          rd_second <= ~rd_second;
        end
      end

      // ------------------------------------------------------------
      // Status latch
      // ------------------------------------------------------------
      // A latched status byte is read ahead of any latched count bytes
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          stat_latched <= 1'b0;
          status       <= 8'h00;
        end else if (status_cmd && !stat_latched) begin
          status       <= {out, null_count, fmt, mode, bcd};
          stat_latched <= 1'b1;
        end else if (cnt_rd && stat_latched) begin
          stat_latched <= 1'b0;
        end
      end

      // Only one snapshot byte reaches the shared read path
      always @* begin
        next_rdata = count_snapshot_latch[7:0];
        if (stat_latched) begin
          next_rdata = status;
        end else if ((fmt == `PIT_FMT_HIGH) || ((fmt == `PIT_FMT_BOTH) && rd_second)) begin
          next_rdata = count_snapshot_latch[15:8];
        end
      end

      assign cnt_rdata[i] = next_rdata;
    end
  endgenerate

endmodule // pit_top

// File: tb/pit_sva.sv
// Concurrent checks on the interval timer bus and counter output ports
`timescale 1ns/100ps
module pit_sva #(
  parameter NUM_CNT = 3
) (
  input wire               clk,
  input wire               rst,
  input wire [7:0]         data_in,
  input wire [7:0]         data_out,
  input wire               data_oe,
  input wire [1:0]         port_select_bits,
  input wire               cs_n,
  input wire               rd_n,
  input wire               wr_n,
  input wire [NUM_CNT-1:0] count_clk,
  input wire [NUM_CNT-1:0] count_enable,
  input wire [NUM_CNT-1:0] count_out
);
  logic [2:0] quiet;
  wire        rd_sel = !cs_n && !rd_n && port_select_bits != 2'h3;
  wire        setup_rd = !cs_n && !rd_n && port_select_bits == 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Helper: cycles with every gate low and no write strobe
  // ----------------------------------------------------------------
  // Writes already in the sync pipeline may still land, so wait a few cycles
  always @(posedge clk or posedge rst) begin
    if (rst)
      quiet <= 3'h0;
    else if (count_enable != '0 || !wr_n)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  end
  sequence s_rd_held;
    rd_sel [*2];
  endsequence
  sequence s_rd_ends;
    data_oe ##1 rd_n;
  endsequence
  a_oe_on_read: assert property (rd_sel |=> data_oe)
    else $error("selected read not answered");
  a_oe_holds: assert property (s_rd_held |-> data_oe)
    else $error("data buffer dropped during read");
  a_cs_gates_read: assert property (cs_n |=> !data_oe)
    else $error("buffer driven without chip select");
  a_setup_unread: assert property (setup_rd |=> !data_oe)
    else $error("setup register was read");
  a_oe_drop: assert property (s_rd_ends |=> !data_oe)
    else $error("buffer still driven after read");
  a_out_zero_idle: assert property (!data_oe |-> data_out == 8'h00)
    else $error("read data not zero when idle");
  a_oe_cause: assert property ($rose(data_oe) |-> $past(rd_sel))
    else $error("buffer driven without read");
  a_out_quiet: assert property (quiet >= 3'h5 |-> $stable(count_out))
    else $error("counter output moved while idle");
endmodule // pit_sva

bind pit_top pit_sva #(.NUM_CNT(NUM_CNT)) i_sva (.clk(clk), .rst(rst), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .port_select_bits(port_select_bits), .cs_n(cs_n),
  .rd_n(rd_n), .wr_n(wr_n), .count_clk(count_clk), .count_enable(count_enable),
  .count_out(count_out));

// File: tb/pit_cpu.sv
// Processor bus model driving the timer's chip select and strobes
`timescale 1ns/100ps
module pit_cpu (
  input  wire        clk,
  input  wire [7:0]  data_out,
  input  wire        data_oe,
  output logic [7:0] data_in,
  output logic [1:0] port_select_bits,
  output logic       cs_n,
  output logic       rd_n,
  output logic       wr_n
);
  initial begin
    data_in = 8'h00;
    port_select_bits = 2'h0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic cs, input logic [1:0] sel, input logic [7:0] d);
    @(posedge clk);
    cs_n <= cs;
    port_select_bits <= sel;
    data_in <= d;
    wr_n <= 1'b0;
    @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
    cs_n <= 1'b1;
    // Released bus must not keep showing the last byte
    data_in <= ~d;
  endtask
  task automatic rd(input logic [1:0] sel, output logic [7:0] d, output logic got);
    int n;
    got = 1'b0;
    d = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    port_select_bits <= sel;
    rd_n <= 1'b0;
    for (n = 0; n < 8 && !got; n++) begin
      @(posedge clk);
      if (data_oe === 1'b1) begin
        got = 1'b1;
        d = data_out;
      end
    end
    rd_n <= 1'b1;
    @(posedge clk);
    cs_n <= 1'b1;
  endtask
endmodule // pit_cpu

// File: tb/testbench.sv
// Self-checking bench for the interval timer bus and programming block
`timescale 1ns/100ps
`include "pit_regs.vh"
module testbench;
  logic        clk, rst, cs_n, rd_n, wr_n, data_oe, got, prev_oe;
  logic [7:0]  data_in, data_out, rb;
  logic [1:0]  port_select_bits;
  logic [2:0]  count_clk, count_enable, count_out;
  logic [15:0] cnt [3];
  logic [7:0]  exp_q [$];
  int          fails, cmp_count, seed;

  pit_top i_dut (.clk(clk), .rst(rst), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .port_select_bits(port_select_bits), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .count_clk(count_clk), .count_enable(count_enable), .count_out(count_out));
  pit_cpu i_cpu (.clk(clk), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .port_select_bits(port_select_bits), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    cmp_count++;
    if (act !== exp) begin
      fails++;
      $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic rd_exp(input logic [1:0] s, input logic [7:0] e);
    exp_q.push_back(e);
    i_cpu.rd(s, rb, got);
    chk({7'h0, got}, 8'h01);
  endtask
  task automatic setup(input logic [1:0] c, input logic [1:0] f, input logic b);
    i_cpu.wr(1'b0, 2'h3, {c, f, 3'h0, b});
  endtask
  task automatic tick(input logic [2:0] m);
    @(posedge clk);
    count_clk <= m;
    repeat (3) @(posedge clk);
    count_clk <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Oldest expected byte is matched to each fresh read answer
  always @(posedge clk) begin
    prev_oe <= data_oe;
    if (data_oe === 1'b1 && prev_oe !== 1'b1) begin
      if (exp_q.size() == 0)
        chk({7'h0, data_oe}, 8'h00);
      else
        chk(data_out, exp_q.pop_front());
    end
  end
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 22;
    fails = 0;
    cmp_count = 0;
    prev_oe = 1'b0;
    rst = 1'b1;
    count_clk = 3'h0;
    count_enable = 3'h0;
    repeat (16) @(posedge clk);
    chk({5'h0, count_out}, 8'h00);
    chk({7'h0, data_oe}, 8'h00);
    rst <= 1'b0;
    // Setups first, then low bytes, then high bytes across counters
    for (int i = 0; i < 3; i++) begin
      cnt[i] = 16'($random(seed)) | 16'h1000;
      setup(i[1:0], `PIT_FMT_BOTH, 1'b0);
    end
    for (int i = 2; i >= 0; i--) i_cpu.wr(1'b0, i[1:0], cnt[i][7:0]);
    for (int i = 0; i < 3; i++) i_cpu.wr(1'b0, i[1:0], cnt[i][15:8]);
    count_enable <= 3'h7;
    tick(3'h7);
    count_enable <= 3'h0;
    for (int i = 0; i < 3; i++) begin
      setup(i[1:0], `PIT_FMT_LATCH, 1'b0);
      rd_exp(i[1:0], cnt[i][7:0]);
      rd_exp(i[1:0], cnt[i][15:8]);
    end
    chk({5'h0, count_out}, 8'h00);
    $display("test programming done");
    // Latched value holds through ticks; a second latch is ignored
    setup(2'h0, `PIT_FMT_LATCH, 1'b0);
    count_enable <= 3'h1;
    tick(3'h1);
    tick(3'h1);
    setup(2'h0, `PIT_FMT_LATCH, 1'b0);
    count_enable <= 3'h0;
    rd_exp(2'h0, cnt[0][7:0]);
    rd_exp(2'h0, cnt[0][15:8]);
    cnt[0] = cnt[0] - 16'h0002;
    rd_exp(2'h0, cnt[0][7:0]);
    rd_exp(2'h0, cnt[0][15:8]);
    rd_exp(2'h1, cnt[1][7:0]);
    rd_exp(2'h1, cnt[1][15:8]);
    $display("test latch done");
    // Unselected setup write and setup register read are refused
    i_cpu.wr(1'b1, 2'h3, 8'h54);
    repeat (3) @(posedge clk);
    chk({5'h0, count_out}, 8'h00);
    i_cpu.rd(2'h3, rb, got);
    chk({7'h0, got}, 8'h00);
    $display("test refusal done");
    // One-byte counts: the unwritten byte must load as zero
    setup(2'h1, `PIT_FMT_LOW, 1'b0);
    setup(2'h2, `PIT_FMT_HIGH, 1'b0);
    i_cpu.wr(1'b0, 2'h1, 8'h02);
    i_cpu.wr(1'b0, 2'h2, 8'h01);
    count_enable <= 3'h6;
    tick(3'h6);
    count_enable <= 3'h0;
    rd_exp(2'h1, 8'h02);
    rd_exp(2'h2, 8'h01);
    count_enable <= 3'h2;
    tick(3'h2);
    tick(3'h2);
    count_enable <= 3'h0;
    repeat (4) @(posedge clk);
    chk({5'h0, count_out}, 8'h02);
    $display("test one byte done");
    // Decimal count, then readback of status and count together
    setup(2'h0, `PIT_FMT_BOTH, 1'b1);
    i_cpu.wr(1'b0, 2'h0, 8'h00);
    i_cpu.wr(1'b0, 2'h0, 8'h01);
    count_enable <= 3'h1;
    tick(3'h1);
    tick(3'h1);
    count_enable <= 3'h0;
    i_cpu.wr(1'b0, 2'h3, 8'hc2);
    rd_exp(2'h0, 8'h31);
    rd_exp(2'h0, 8'h99);
    rd_exp(2'h0, 8'h00);
    chk(8'(exp_q.size()), 8'h00);
    $display("test decimal done");
    end_sim();
  end
endmodule // testbench
